// [fsl_cmd.sv]
// Serial command decoder: security read, block locks and software reset.
// Assumes link pins from an outside host, sampled by the 50 MHz sys_clk.
module fsl_cmd (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Serial link
  input  wire logic        link_sclk,
  input  wire logic        link_cs_n,
  input  wire logic        link_mosi,
  output logic             link_miso_out,
  output logic             link_miso_oe_n,
  // Device status
  input  wire logic        busy,
  input  wire logic        write_enable_latch,
  // Protection configuration
  input  wire logic        protect_scheme_select,
  input  wire logic        protect_complement,
  input  wire logic        sector_granularity,
  input  wire logic        top_bottom_select,
  input  wire logic [2:0]  protect_range_field,
  input  wire logic [23:0] prot_query_addr,
  output logic             prot_query_locked,
  // Security register load port
  input  wire logic        sec_load_en,
  input  wire logic [9:0]  sec_load_addr,
  input  wire logic [7:0]  sec_load_data,
  // Reset results
  output logic             soft_reset_pulse,
  output logic             reset_recovering,
  output logic             reset_enable_armed
);

  typedef struct packed {
    logic [2:0]             sclk_s;
    logic [2:0]             cs_s;
    logic [1:0]             mosi_s;
    fsl_pkg::fsl_state_e    st;
    logic [5:0]             bits;
    logic [31:0]            sh;
    logic [7:0]             op;
    logic [23:0]            addr;
    logic                   fetch_on;
    logic [7:0]             fetch_addr;
    logic [7:0]             out_sh;
    logic [2:0]             dbit;
    logic                   oe;
    logic                   do_bit;
    logic                   armed;
    logic                   soft_rst;
    logic [10:0]            rec_cnt;
    logic [fsl_pkg::N_LOCK-1:0] locks;
    logic                   query;
  } fsl_cmd_s;

  fsl_cmd_s r_reg;
  fsl_cmd_s r_next;

  logic [7:0] sec_mem [0:fsl_pkg::SEC_WORDS-1];
  logic [7:0] fetch_data;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       pop;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_high;

  ////////////////////////////////////////////////////////////////////////
  // Lock unit index: 16 bottom sectors, 16 top sectors, then blocks
  function automatic logic [7:0] lock_idx(input logic [23:0] a);
    logic [6:0] blk;
    logic [7:0] sec;
    blk = a[fsl_pkg::BLK_HI:fsl_pkg::BLK_LO];
    sec = {4'h0, a[fsl_pkg::SEC_HI:fsl_pkg::SEC_LO]};
    if (blk == 7'h00) begin
      lock_idx = sec;
    end else if (blk == fsl_pkg::LAST_BLK) begin
      lock_idx = 8'(fsl_pkg::TOP_SEC_BASE + sec);
    end else begin
      lock_idx = 8'(fsl_pkg::BLK_BASE + {1'b0, blk});
    end
  endfunction : lock_idx

  // Range protection from the status-register fields
  function automatic logic range_prot(input logic [23:0] a);
    logic [6:0] blk;
    logic [3:0] sec;
    logic [7:0] pos;
    logic [7:0] lim;
    logic       hit;
    blk = a[fsl_pkg::BLK_HI:fsl_pkg::BLK_LO];
    sec = a[fsl_pkg::SEC_HI:fsl_pkg::SEC_LO];
    lim = 8'(8'h01 << (protect_range_field - 3'h1));
    if (sector_granularity) begin
      pos = {4'h0, top_bottom_select ? sec : ~sec};
      hit = (top_bottom_select ? blk == 7'h00 : blk == fsl_pkg::LAST_BLK)
            && pos < lim;
    end else begin
      pos = {1'b0, top_bottom_select ? blk : ~blk};
      hit = pos < lim;
    end
    if (protect_range_field == 3'h0) begin
      hit = 1'b0;
    end else if (protect_range_field == fsl_pkg::BP_ALL) begin
      hit = 1'b1;
    end
    range_prot = hit ^ protect_complement;
  endfunction : range_prot

  ////////////////////////////////////////////////////////////////////////
  // Security register storage and prefetch
  always_ff @(posedge sys_clk) begin
    if (sec_load_en) begin
      sec_mem[sec_load_addr] <= sec_load_data;
    end
  end

  always_comb begin
    logic [1:0] sel;
    sel = r_reg.addr[fsl_pkg::SEL_HI:fsl_pkg::SEC_LO];
    if (sel == 2'h0) begin
      fetch_data = fsl_pkg::BLANK_BYTE;
    end else begin
      fetch_data = sec_mem[{2'(sel - 2'h1), r_reg.fetch_addr}];
    end
  end

  fsl_buf #(
    .W (8)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (cs_high),
    .in_valid  (r_reg.fetch_on),
    .in_data   (fetch_data),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Edges seen on the synchronised pins
  assign sclk_rise = r_reg.sclk_s[1] && !r_reg.sclk_s[2];
  assign sclk_fall = !r_reg.sclk_s[1] && r_reg.sclk_s[2];
  assign cs_high   = r_reg.cs_s[1];
  assign cs_rise   = r_reg.cs_s[1] && !r_reg.cs_s[2];
  assign pop = !cs_high && sclk_fall && r_reg.st == fsl_pkg::ST_DATA
               && r_reg.dbit == 3'h0 && r_reg.op == fsl_pkg::OP_SEC_READ;

  always_comb begin
    logic [31:0] sh_in;
    logic [7:0]  byte_out;
    sh_in = {r_reg.sh[30:0], r_reg.mosi_s[1]};
    byte_out = 8'h00;
    r_next = r_reg;
    r_next.sclk_s = {r_reg.sclk_s[1:0], link_sclk};
    r_next.cs_s = {r_reg.cs_s[1:0], link_cs_n};
    r_next.mosi_s = {r_reg.mosi_s[0], link_mosi};
    r_next.soft_rst = 1'b0;
    if (r_reg.rec_cnt != 11'h000) begin
      r_next.rec_cnt = 11'(r_reg.rec_cnt - 11'h001);
    end
    if (r_reg.fetch_on && buf_in_ready) begin
      r_next.fetch_addr = 8'(r_reg.fetch_addr + 8'h01);
    end
    r_next.query = protect_scheme_select
                   ? r_reg.locks[lock_idx(prot_query_addr)]
                   : range_prot(prot_query_addr);
    if (cs_high) begin
      r_next.st = fsl_pkg::ST_IDLE;
      r_next.bits = 6'h00;
      r_next.oe = 1'b0;
      r_next.fetch_on = 1'b0;
      r_next.dbit = 3'h0;
      if (cs_rise && r_reg.rec_cnt == 11'h000
          && r_reg.bits >= fsl_pkg::BITS_OP) begin
        r_next.armed = r_reg.op == fsl_pkg::OP_RST_ENABLE
                       && r_reg.bits == fsl_pkg::BITS_OP;
        if (r_reg.op == fsl_pkg::OP_RST_DEVICE && r_reg.armed
            && r_reg.bits == fsl_pkg::BITS_OP) begin
          r_next.soft_rst = 1'b1;
          r_next.locks = '1;
          r_next.rec_cnt = fsl_pkg::RST_CYC;
        end else if (write_enable_latch) begin
          if (r_reg.bits == fsl_pkg::BITS_ADDR
              && r_reg.op == fsl_pkg::OP_LOCK) begin
            r_next.locks[lock_idx(r_reg.addr)] = 1'b1;
          end
          if (r_reg.bits == fsl_pkg::BITS_ADDR
              && r_reg.op == fsl_pkg::OP_UNLOCK) begin
            r_next.locks[lock_idx(r_reg.addr)] = 1'b0;
          end
          if (r_reg.bits == fsl_pkg::BITS_OP
              && r_reg.op == fsl_pkg::OP_GLOB_LOCK) begin
            r_next.locks = '1;
          end
          if (r_reg.bits == fsl_pkg::BITS_OP
              && r_reg.op == fsl_pkg::OP_GLOB_UNLK) begin
            r_next.locks = '0;
          end
        end
      end
    end else if (sclk_rise) begin
      r_next.sh = sh_in;
      if (r_reg.bits != fsl_pkg::BITS_MAX) begin
        r_next.bits = 6'(r_reg.bits + 6'h01);
      end
      unique case (r_reg.st)
        fsl_pkg::ST_IDLE: begin
          if (r_reg.bits == fsl_pkg::BITS_OP - 6'h01) begin
            r_next.op = sh_in[7:0];
            r_next.st = fsl_pkg::ST_HOLD;
            if (r_reg.rec_cnt == 11'h000) begin
              if (sh_in[7:0] == fsl_pkg::OP_SEC_READ) begin
                if (!busy) begin
                  r_next.st = fsl_pkg::ST_ADDR;
                end
              end else if (sh_in[7:0] == fsl_pkg::OP_LOCK_READ
                           || sh_in[7:0] == fsl_pkg::OP_LOCK
                           || sh_in[7:0] == fsl_pkg::OP_UNLOCK) begin
                r_next.st = fsl_pkg::ST_ADDR;
              end
            end
          end
        end
        fsl_pkg::ST_ADDR: begin
          if (r_reg.bits == fsl_pkg::BITS_ADDR - 6'h01) begin
            r_next.addr = sh_in[23:0];
            r_next.st = fsl_pkg::ST_HOLD;
            if (r_reg.op == fsl_pkg::OP_SEC_READ) begin
              r_next.st = fsl_pkg::ST_DUMMY;
              r_next.fetch_on = 1'b1;
              r_next.fetch_addr = sh_in[7:0];
            end else if (r_reg.op == fsl_pkg::OP_LOCK_READ) begin
              r_next.st = fsl_pkg::ST_DATA;
            end
          end
        end
        fsl_pkg::ST_DUMMY: begin
          if (r_reg.bits == fsl_pkg::BITS_DUMMY - 6'h01) begin
            r_next.st = fsl_pkg::ST_DATA;
          end
        end
        fsl_pkg::ST_DATA, fsl_pkg::ST_HOLD: begin
        end
      endcase
    end else if (sclk_fall && r_reg.st == fsl_pkg::ST_DATA) begin
      r_next.oe = 1'b1;
      r_next.dbit = 3'(r_reg.dbit + 3'h1);
      if (r_reg.dbit == 3'h0) begin
        if (r_reg.op == fsl_pkg::OP_SEC_READ) begin
          byte_out = buf_out_data;
        end else begin
          byte_out = {7'h00, r_reg.locks[lock_idx(r_reg.addr)]};
        end
        r_next.do_bit = byte_out[7];
        r_next.out_sh = {byte_out[6:0], 1'b0};
      end else begin
        r_next.do_bit = r_reg.out_sh[7];
        r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= fsl_pkg::ST_IDLE;
      r_reg.sclk_s <= 3'h0;
      r_reg.cs_s <= 3'h7;
      r_reg.locks <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link_miso_out      = r_reg.do_bit;
  assign link_miso_oe_n     = !r_reg.oe;
  assign prot_query_locked  = r_reg.query;
  assign soft_reset_pulse   = r_reg.soft_rst;
  assign reset_recovering   = r_reg.rec_cnt != 11'h000;
  assign reset_enable_armed = r_reg.armed;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sec_busy_ignore: assert property (
    r_reg.st == fsl_pkg::ST_IDLE && !cs_high && sclk_rise && busy
    && r_reg.bits == 6'h07 && {r_reg.sh[6:0], r_reg.mosi_s[1]} == 8'h48
    |=> r_reg.st == fsl_pkg::ST_HOLD)
    else $error("security read not ignored while busy");

  a_reset_needs_arm: assert property (
    soft_reset_pulse |-> $past(r_reg.armed) && $past(r_reg.op) == 8'h99)
    else $error("reset without enable");

  a_reset_locks_set: assert property (
    soft_reset_pulse |-> &r_reg.locks)
    else $error("locks not set by reset");

  a_reset_recovery: assert property (
    soft_reset_pulse |-> r_reg.rec_cnt == 11'd1500 ##1
    r_reg.rec_cnt == 11'd1499)
    else $error("recovery count wrong");

  a_recovery_reject: assert property (
    reset_recovering && cs_rise |=> !soft_reset_pulse
    && r_reg.locks == $past(r_reg.locks))
    else $error("command taken during recovery");

  a_wel_guard: assert property (
    cs_rise && !write_enable_latch && r_reg.op != 8'h99
    |=> r_reg.locks == $past(r_reg.locks))
    else $error("locks changed without write enable");

  a_glob_lock: assert property (
    cs_rise && write_enable_latch && !reset_recovering
    && r_reg.bits == 6'h08 && r_reg.op == 8'h7E |=> &r_reg.locks)
    else $error("global lock failed");

  a_glob_unlock: assert property (
    cs_rise && write_enable_latch && !reset_recovering
    && r_reg.bits == 6'h08 && r_reg.op == 8'h98 |=> r_reg.locks == '0)
    else $error("global unlock failed");

  a_addr_wrap: assert property (
    r_reg.fetch_on && buf_in_ready && r_reg.fetch_addr == 8'hFF && !cs_high
    |=> r_reg.fetch_addr == 8'h00)
    else $error("byte address did not wrap");

  a_out_on_fall: assert property (
    !link_miso_oe_n && $changed(link_miso_out) |-> $past(sclk_fall))
    else $error("data changed off a falling edge");

  c_soft_reset: cover property (soft_reset_pulse);
  c_sec_stream: cover property (pop ##1 !link_miso_oe_n);
  c_lock_read: cover property (
    r_reg.op == 8'h3D && r_reg.st == fsl_pkg::ST_DATA && !link_miso_oe_n);
  c_glob_unlock: cover property (r_reg.locks == '0);

endmodule : fsl_cmd

// [fsl_pkg.sv]
// Constants, opcodes and state codes for the flash lock/reset command block.
// Assumes a 50 MHz system clock that samples the serial link pins.
//
// Summary of operation
// - Opcode 48h, 24-bit address, eight dummy clocks.
// - Opcode and address taken on clock rising.
// - Data shifted out MSB first on falling.
// - Byte address increments, wraps FFh to 00h.
// - Security read ignored while a cycle runs.
// - Lock bits count only when scheme select set.
// - Lock bits start at one after reset.
// - Opcode 36h plus address locks one unit.
// - Opcode 39h plus address unlocks one unit.
// - Lock commands need the write enable latch.
// - Opcode 3Dh reads a lock bit, LSB.
// - Opcode 7Eh sets every lock bit.
// - Opcode 98h clears every lock bit.
// - Reset only when 66h directly precedes 99h.
// - Any other command cancels reset enable.
// - Accepted reset sets every lock bit to one.
// - Commands rejected during reset recovery time.
package fsl_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OP_SEC_READ   = 8'h48;
  localparam logic [7:0] OP_LOCK       = 8'h36;
  localparam logic [7:0] OP_UNLOCK     = 8'h39;
  localparam logic [7:0] OP_LOCK_READ  = 8'h3D;
  localparam logic [7:0] OP_GLOB_LOCK  = 8'h7E;
  localparam logic [7:0] OP_GLOB_UNLK  = 8'h98;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_DEVICE = 8'h99;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [5:0] BITS_OP    = 6'h08;
  localparam logic [5:0] BITS_ADDR  = 6'h20;
  localparam logic [5:0] BITS_DUMMY = 6'h28;
  localparam logic [5:0] BITS_MAX   = 6'h3F;

  ////////////////////////////////////////////////////////////////////////
  localparam int         N_LOCK     = 158;
  localparam logic [7:0] TOP_SEC_BASE = 8'h10;
  localparam logic [7:0] BLK_BASE   = 8'h1F;
  localparam logic [6:0] LAST_BLK   = 7'h7F;
  localparam int         BLK_HI     = 22;
  localparam int         BLK_LO     = 16;
  localparam int         SEC_HI     = 15;
  localparam int         SEC_LO     = 12;
  localparam int         SEL_HI     = 13;
  localparam int         SEC_WORDS  = 768;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [2:0] BP_ALL     = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  localparam int         CLK_HZ     = 50_000_000;
  localparam int         T_RST_US   = 30;
  localparam logic [10:0] RST_CYC   = 11'(CLK_HZ / 1_000_000 * T_RST_US);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_DUMMY = 5'b00100,
    ST_DATA  = 5'b01000,
    ST_HOLD  = 5'b10000
  } fsl_state_e;

endpackage : fsl_pkg

// [fsl_buf.sv]
// Two-entry buffer between the byte fetch and the serial shifter.
// Assumes producer and consumer both run on sys_clk.
module fsl_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         flush,
  // Filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0]   cnt;
  } fsl_buf_s;

  fsl_buf_s buf_reg;
  fsl_buf_s buf_next;

  assign in_ready  = buf_reg.cnt != 2'h2;
  assign out_valid = buf_reg.cnt != 2'h0;
  assign out_data  = buf_reg.d0;

  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    buf_next = buf_reg;
    if (pop) begin
      buf_next.d0 = buf_reg.d1;
    end
    if (push) begin
      if (buf_reg.cnt == 2'h0 || (buf_reg.cnt == 2'h1 && pop)) begin
        buf_next.d0 = in_data;
      end else begin
        buf_next.d1 = in_data;
      end
    end
    buf_next.cnt = 2'(buf_reg.cnt + {1'b0, push} - {1'b0, pop});
    if (flush) begin
      buf_next.cnt = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end

  a_buf_no_overflow: assert property (@(posedge sys_clk) disable iff (rst)
    buf_reg.cnt <= 2'h2)
    else $error("buffer count out of range");

endmodule : fsl_buf

// [fsl_host_model.sv]
// Serial host model: drives select, clock and data in, samples data out.
// Assumes the link clock stands low outside frames, 160 ns period.
module fsl_host_model (
  // Link outputs
  output logic      link_sclk,
  output logic      link_cs_n,
  output logic      link_mosi,
  // Link inputs
  input  wire logic link_miso_out,
  input  wire logic link_miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 80;
  logic [7:0] rx [0:3];
  logic       saw_drive;
  logic       last_miso;
  logic       miso_line;

  ////////////////////////////////////////////////////////////////////////
  // Released line shows the inverse of its last driven value
  always_comb miso_line = link_miso_oe_n ? ~last_miso : link_miso_out;
  always @(link_miso_out) begin
    if (link_miso_oe_n === 1'h0)
      last_miso = link_miso_out;
  end

  initial begin
    link_sclk = 1'h0;
    link_cs_n = 1'h1;
    link_mosi = 1'h0;
    saw_drive = 1'h0;
    last_miso = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic send_bit(input logic b);
    link_mosi = b;
    #HALF link_sclk = 1'h1;
    #HALF link_sclk = 1'h0;
  endtask : send_bit

  // One frame: opcode, address, dummy clocks, read bytes, optional stall
  task automatic frame(input logic [7:0] op, input int nadr,
                       input logic [23:0] adr, input int ndum,
                       input int nrd, input int gap);
    #7;
    saw_drive = 1'h0;
    link_cs_n = 1'h0;
    #HALF;
    for (int i = 7; i >= 0; i--) send_bit(op[i]);
    for (int i = nadr - 1; i >= 0; i--) send_bit(adr[i]);
    for (int i = 0; i < ndum; i++) send_bit(~link_mosi);
    for (int b = 0; b < nrd; b++) begin
      #gap;
      for (int i = 7; i >= 0; i--) begin
        #HALF link_sclk = 1'h1;
        rx[b][i] = miso_line;
        if (link_miso_oe_n === 1'h0)
          saw_drive = 1'h1;
        #HALF link_sclk = 1'h0;
      end
    end
    #HALF link_cs_n = 1'h1;
    link_mosi = ~link_mosi;
    #200;
  endtask : frame
endmodule : fsl_host_model

// [tb.sv]
// Self-checking bench of the lock, security read and reset decoder.
// Assumes fsl_pkg and fsl_cmd are compiled before this file.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [7:0] op; logic we; logic ex;} fsl_row_s;
  localparam logic [23:0] QA = 24'h050000;
  logic        sys_clk, rst, busy, we_latch, scheme_sel, query_lk;
  logic [2:0]  range_f;
  logic        rng_inv, gran_4k, from_bot;
  logic        ld_en, sclk, cs_n, mosi, miso, oe_n, rst_pulse, rec, armed;
  logic [9:0]  ld_adr;
  logic [7:0]  ld_dat;
  int          errors, n_tests, cyc, n_pulse, n_rec;
  logic [9:0]  sidx [4] = '{10'h1FE, 10'h1FF, 10'h100, 10'h101};
  logic [7:0]  sval [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
  fsl_row_s    rows [6] = '{'{fsl_pkg::OP_UNLOCK, 1'h1, 1'h0},
                            '{fsl_pkg::OP_LOCK, 1'h1, 1'h1},
                            '{fsl_pkg::OP_UNLOCK, 1'h0, 1'h1},
                            '{fsl_pkg::OP_GLOB_UNLK, 1'h1, 1'h0},
                            '{fsl_pkg::OP_GLOB_LOCK, 1'h0, 1'h0},
                            '{fsl_pkg::OP_GLOB_LOCK, 1'h1, 1'h1}};
  // Range rows: {complement, granularity, from bottom, range, expected}
  logic [6:0]  prow [7] = '{7'h00, 7'h41, 7'h0F, 7'h16, 7'h19, 7'h38, 7'h08};

  fsl_cmd u_dut (.sys_clk(sys_clk), .rst(rst), .link_sclk(sclk),
    .link_cs_n(cs_n), .link_mosi(mosi), .link_miso_out(miso),
    .link_miso_oe_n(oe_n), .busy(busy), .write_enable_latch(we_latch),
    .protect_scheme_select(scheme_sel), .protect_complement(rng_inv),
    .sector_granularity(gran_4k), .top_bottom_select(from_bot),
    .protect_range_field(range_f), .prot_query_addr(QA),
    .prot_query_locked(query_lk), .sec_load_en(ld_en),
    .sec_load_addr(ld_adr), .sec_load_data(ld_dat),
    .soft_reset_pulse(rst_pulse), .reset_recovering(rec),
    .reset_enable_armed(armed));

  fsl_host_model u_host (.link_sclk(sclk), .link_cs_n(cs_n),
    .link_mosi(mosi), .link_miso_out(miso), .link_miso_oe_n(oe_n));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (rst_pulse === 1'h1)
      n_pulse++;
    if (rec === 1'h1)
      n_rec++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic cmd(input logic [7:0] op);
    @(posedge sys_clk);
    u_host.frame(op, (op == fsl_pkg::OP_LOCK || op == fsl_pkg::OP_UNLOCK)
                 ? 24 : 0, QA, 0, 0, 0);
  endtask : cmd

  task automatic lock_check(input logic e);
    @(posedge sys_clk);
    u_host.frame(fsl_pkg::OP_LOCK_READ, 24, QA, 0, 1, 0);
    @(posedge sys_clk);
    `CHK("lock_read", {7'h00, e}, u_host.rx[0])
    `CHK("query", e, query_lk)
  endtask : lock_check

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst <= 1'h1;
    busy <= 1'h0;
    we_latch <= 1'h1;
    scheme_sel <= 1'h1;
    range_f <= 3'h0;
    {rng_inv, gran_4k, from_bot} <= 3'h0;
    ld_en <= 1'h0;
    ld_adr <= 10'h000;
    ld_dat <= 8'h00;
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    `CHK("reset_lock", 1'h1, query_lk)
    `CHK("idle_oe_n", 1'h1, oe_n)
    for (int i = 0; i < 6; i++) begin
      we_latch <= rows[i].we;
      cmd(rows[i].op);
      lock_check(rows[i].ex);
    end
    we_latch <= 1'h1;
    // Range scheme ignores the per-unit bits
    scheme_sel <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      {rng_inv, gran_4k, from_bot, range_f} <= prow[i][6:1];
      repeat (3) @(posedge sys_clk);
      `CHK("range", prow[i][0], query_lk)
    end
    {rng_inv, gran_4k, from_bot} <= 3'h0;
    range_f <= fsl_pkg::BP_ALL;
    scheme_sel <= 1'h1;
    // Security register bytes around the wrap point
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      ld_en <= 1'h1;
      ld_adr <= sidx[k];
      ld_dat <= sval[k];
    end
    @(posedge sys_clk);
    ld_en <= 1'h0;
    u_host.frame(fsl_pkg::OP_SEC_READ, 24, 24'h0020FE, 8, 3, 0);
    for (int k = 0; k < 3; k++)
      `CHK("sec_byte", sval[k], u_host.rx[k])
    `CHK("oe_n_end", 1'h1, oe_n)
    // Host stalls between bytes
    u_host.frame(fsl_pkg::OP_SEC_READ, 24, 24'h0020FF, 8, 3, 2000);
    for (int k = 0; k < 3; k++)
      `CHK("slow_byte", sval[k + 1], u_host.rx[k])
    @(posedge sys_clk);
    busy <= 1'h1;
    u_host.frame(fsl_pkg::OP_SEC_READ, 24, 24'h0020FE, 8, 1, 0);
    `CHK("busy_drive", 1'h0, u_host.saw_drive)
    @(posedge sys_clk);
    busy <= 1'h0;
    // Reset pair, first broken by another command
    cmd(fsl_pkg::OP_GLOB_UNLK);
    cmd(fsl_pkg::OP_RST_ENABLE);
    `CHK("armed", 1'h1, armed)
    lock_check(1'h0);
    `CHK("disarmed", 1'h0, armed)
    cmd(fsl_pkg::OP_RST_DEVICE);
    `CHK("no_reset", 0, n_pulse)
    cmd(fsl_pkg::OP_RST_ENABLE);
    cmd(fsl_pkg::OP_RST_DEVICE);
    `CHK("reset_pulse", 1, n_pulse)
    `CHK("recovering", 1'h1, rec)
    `CHK("locks_set", 1'h1, query_lk)
    cmd(fsl_pkg::OP_GLOB_UNLK);
    `CHK("recov_reject", 1'h1, query_lk)
    for (int w = 0; w < 2000 && rec !== 1'h0; w++)
      @(posedge sys_clk);
    `CHK("recov_len", 1500, n_rec)
    cmd(fsl_pkg::OP_GLOB_UNLK);
    lock_check(1'h0);
    wrap_up();
  end
endmodule : tb
